// *** core/rfc_regs.sv ***
// Converter control and counter registers behind an AHB-Lite slave
// Behaviour
// R1: divider field divides clock 1,2,4,8; the code leaves the low-speed source undivided
// R2: source field picks internal, low, high oscillator
// R3: control bit selects event counter mode
// R4: two-bit field selects sensor oscillation type
// R5: sensor B bit starts, stops, shows run
// R6: sensor A bit starts, stops, shows run
// R7: low time base half readable and writable
// R8: high time base byte, upper bits zero
// R9: time base overflow sets write-one-clear flag
// R10: oscillation completion sets write-one-clear flags
// R11: 24-bit measurement counter, low and high
//
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/10ps
`include "rfc_defines.svh"

module rfc_regs (
  input  wire logic        ref_clk,      // 25 MHz clock
  input  wire logic        sys_rst,      // Synchronous reset
  input  wire logic        ce,           // Clock enable
  input  wire logic        hsel,         // Slave select
  input  wire logic [31:0] haddr,        // Byte address
  input  wire logic [1:0]  htrans,       // Transfer type
  input  wire logic        hwrite,       // Write when high
  input  wire logic [2:0]  hsize,        // Word only
  input  wire logic [31:0] hwdata,       // Write data
  input  wire logic        hready,       // Bus ready
  output logic             hreadyout,    // Slave ready
  output logic             hresp,        // Always OKAY
  output logic      [31:0] hrdata,       // Read data
  input  wire logic        int_osc_tick, // Internal oscillator tick
  input  wire logic        low_osc_tick, // Low-speed oscillator tick
  input  wire logic        hi_osc_tick,  // High-speed oscillator tick
  input  wire logic        osc_edge,     // Edge of running oscillation
  output logic             ref_drive,    // Reference oscillation drive
  output logic             sens_a_drive, // Sensor A oscillation drive
  output logic             sens_b_drive, // Sensor B oscillation drive
  output logic      [1:0]  osc_type_out, // Sensor oscillation type
  output logic             channel_out,  // Conversion channel
  output logic             irq           // Level interrupt
);

  function automatic logic [2:0] div_mask(input logic [1:0] d);
    div_mask = 3'((4'h1 << d) - 4'h1);
  endfunction : div_mask

  function automatic logic idx_hit(input logic [15:0] a,
                                   input logic [15:0] b);
    idx_hit = (a == b);
  endfunction : idx_hit

  rfc_pkg::rfc_bus_state_type bus_state;
  rfc_pkg::converter_clock_setup_src_type   converter_clk_source_sel;
  logic [1:0]  converter_clk_divider;
  logic        converter_clk_gate_on;
  logic        continuous_osc_on;
  logic        event_count_mode_on;
  logic [1:0]  sensor_osc_type;
  logic        channel_pick;
  logic        converter_on;
  logic        reference_osc_run;
  logic        sensor_a_osc_run;
  logic        sensor_b_osc_run;
  logic [23:0] measurement_count;
  logic [23:0] time_base_count;
  logic [4:0]  flag;
  logic [4:0]  mask;
  logic [2:0]  div_cnt;
  logic        ap_ok;
  logic [15:0] ap_idx;
  logic        take;
  logic        wr_en;
  logic        wr_clk, wr_ctl, wr_trg, wr_mcl, wr_mch;
  logic        wr_tcl, wr_tch, wr_imsk, wr_iflg;
  logic [31:0] rd_value;
  logic        src_tick, divide_on, conv_tick;
  logic        sel_ref, sel_a, sel_b, osc_active;
  logic        meas_step, meas_wrap, done_any, tb_step, tb_wrap;
  logic [4:0]  next_flag;
  logic [4:0]  flag_set;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  // Bus slave
  assign take  = hsel && htrans[1] && hready;
  assign wr_en = (bus_state == rfc_pkg::RFC_BUS_WRITE) && ap_ok;

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      bus_state <= rfc_pkg::RFC_BUS_IDLE;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0;
      ap_ok     <= 1'b0;
      ap_idx    <= 16'h0;
    end
    else if (ce)
    begin
      case (bus_state)
        rfc_pkg::RFC_BUS_READ_WAIT:
        begin
          // A wait state lets a write just before be seen
          hrdata    <= rd_value;
          hreadyout <= 1'b1;
          bus_state <= rfc_pkg::RFC_BUS_READ_DONE;
        end
        default:
        begin
          if (take)
          begin
            ap_ok  <= (haddr[31:18] == `RFC_IDX_TOP_ZERO)
                      && (haddr[1:0] == 2'b00);
            ap_idx <= haddr[17:2];
            if (hwrite)
              bus_state <= rfc_pkg::RFC_BUS_WRITE;
            else
            begin
              bus_state <= rfc_pkg::RFC_BUS_READ_WAIT;
              hreadyout <= 1'b0;
            end
          end
          else
            bus_state <= rfc_pkg::RFC_BUS_IDLE;
        end
      endcase
    end
  end

  always_comb
  begin
    wr_clk  = 1'b0;
    wr_ctl  = 1'b0;
    wr_trg  = 1'b0;
    wr_mcl  = 1'b0;
    wr_mch  = 1'b0;
    wr_tcl  = 1'b0;
    wr_tch  = 1'b0;
    wr_imsk = 1'b0;
    wr_iflg = 1'b0;
    if (!wr_en)
      wr_clk = 1'b0;
    else if (idx_hit(ap_idx, `RFC_IDX_CLK))
      wr_clk = 1'b1;
    else if (idx_hit(ap_idx, `RFC_IDX_CTL))
      wr_ctl = 1'b1;
    else if (idx_hit(ap_idx, `RFC_IDX_TRG))
      wr_trg = 1'b1;
    else if (idx_hit(ap_idx, `RFC_IDX_MCL))
      wr_mcl = 1'b1;
    else if (idx_hit(ap_idx, `RFC_IDX_MCH))
      wr_mch = 1'b1;
    else if (idx_hit(ap_idx, `RFC_IDX_TCL))
      wr_tcl = 1'b1;
    else if (idx_hit(ap_idx, `RFC_IDX_TCH))
      wr_tch = 1'b1;
    else if (idx_hit(ap_idx, `RFC_IDX_IMSK))
      wr_imsk = 1'b1;
    else if (idx_hit(ap_idx, `RFC_IDX_IFLG))
      wr_iflg = 1'b1;
  end

  // Unmapped words read as zero; reserved bits read as zero
  always_comb
  begin
    rd_value = 32'h0;
    if (!ap_ok)
      rd_value = 32'h0;
    else if (idx_hit(ap_idx, `RFC_IDX_CLK))
      rd_value = {26'h0, converter_clk_divider, converter_clk_source_sel,
                  1'b0, converter_clk_gate_on};
    else if (idx_hit(ap_idx, `RFC_IDX_CTL))
      rd_value = {24'h0, continuous_osc_on, event_count_mode_on,
                  sensor_osc_type, 2'b00, channel_pick, converter_on};
    else if (idx_hit(ap_idx, `RFC_IDX_TRG))
      rd_value = {29'h0, sensor_b_osc_run, sensor_a_osc_run,
                  reference_osc_run};
    else if (idx_hit(ap_idx, `RFC_IDX_MCL))
      rd_value = {16'h0, measurement_count[15:0]};
    else if (idx_hit(ap_idx, `RFC_IDX_MCH))
      rd_value = {24'h0, measurement_count[23:16]};
    else if (idx_hit(ap_idx, `RFC_IDX_TCL))
      rd_value = {16'h0, time_base_count[15:0]};
    else if (idx_hit(ap_idx, `RFC_IDX_TCH))
      rd_value = {24'h0, time_base_count[23:16]};                 // R8
    else if (idx_hit(ap_idx, `RFC_IDX_IMSK))
      rd_value = {27'h0, mask};
    else if (idx_hit(ap_idx, `RFC_IDX_IFLG))
      rd_value = {27'h0, flag};
  end

  // Configuration
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      converter_clk_divider    <= `RFC_DIV_RST;
      converter_clk_source_sel <= rfc_pkg::RFC_SRC_LOW_SPEED;
      converter_clk_gate_on    <= 1'b0;
      continuous_osc_on        <= 1'b0;
      event_count_mode_on      <= 1'b0;
      sensor_osc_type          <= `RFC_MODE_RST;
      channel_pick             <= 1'b0;
      converter_on             <= 1'b0;
      mask                     <= `RFC_FLAG_NONE;
    end
    else if (ce)
    begin
      if (wr_clk)
      begin
        converter_clk_divider    <=
          hwdata[`CONVERTER_CLOCK_SETUP_DIV_HI:`CONVERTER_CLOCK_SETUP_DIV_LO];                 // R1
        converter_clk_source_sel <= rfc_pkg::converter_clock_setup_src_type'(
          hwdata[`CONVERTER_CLOCK_SETUP_SRC_HI:`CONVERTER_CLOCK_SETUP_SRC_LO]);                 // R2
        converter_clk_gate_on    <= hwdata[`CONVERTER_CLOCK_SETUP_GATE];
      end
      if (wr_ctl)
      begin
        continuous_osc_on   <= hwdata[`CONVERTER_CONTROL_CONT];
        event_count_mode_on <= hwdata[`CONVERTER_CONTROL_EVT];               // R3
        sensor_osc_type     <=
          hwdata[`CONVERTER_CONTROL_MODE_HI:`CONVERTER_CONTROL_MODE_LO];               // R4
        channel_pick        <= hwdata[`CONVERTER_CONTROL_CHAN];
        converter_on        <= hwdata[`CONVERTER_CONTROL_ON];
      end
      if (wr_imsk)
        mask <= hwdata[`RFC_NFLAG-1:0];
    end
  end

  // Converter clock: the low-speed source is never divided
  always_comb
  begin
    case (converter_clk_source_sel)
      rfc_pkg::RFC_SRC_INTERNAL:  src_tick = int_osc_tick;         // R2
      rfc_pkg::RFC_SRC_LOW_SPEED: src_tick = low_osc_tick;
      rfc_pkg::RFC_SRC_HIGH_SPD:  src_tick = hi_osc_tick;
      default:                    src_tick = 1'b0;
    endcase
  end

  assign divide_on = converter_clk_source_sel != rfc_pkg::RFC_SRC_LOW_SPEED;
  assign conv_tick = converter_clk_gate_on && src_tick
    && (!divide_on || ((div_cnt & div_mask(converter_clk_divider))
                       == div_mask(converter_clk_divider)));     // R1

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      div_cnt <= `RFC_DIVCNT_RST;
    else if (ce)
    begin
      if (!converter_clk_gate_on)
        div_cnt <= `RFC_DIVCNT_RST;
      else if (src_tick)
        div_cnt <= div_cnt + `RFC_DIVCNT_ONE;
    end
  end

  // One oscillation counts at a time; the reference has priority
  assign sel_ref    = reference_osc_run;
  assign sel_a      = !reference_osc_run && sensor_a_osc_run;
  assign sel_b      = !reference_osc_run && !sensor_a_osc_run
                      && sensor_b_osc_run;
  assign osc_active = converter_on && (sel_ref || sel_a || sel_b);
  assign meas_step  = osc_active && osc_edge;
  assign meas_wrap  = meas_step && (measurement_count == `RFC_CNT_MAX);
  assign done_any   = meas_wrap && !event_count_mode_on;
  assign tb_step    = osc_active && !event_count_mode_on && conv_tick;
  assign tb_wrap    = tb_step && (sel_ref ?
                      (time_base_count == `RFC_CNT_MAX) :
                      (time_base_count == `RFC_CNT_RST));

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      reference_osc_run <= 1'b0;
      sensor_a_osc_run  <= 1'b0;
      sensor_b_osc_run  <= 1'b0;
    end
    else if (ce)
    begin
      if (wr_trg)
      begin
        reference_osc_run <= hwdata[`OSCILLATION_TRIGGER_REF];
        sensor_a_osc_run  <= hwdata[`OSCILLATION_TRIGGER_A];                   // R6
        sensor_b_osc_run  <= hwdata[`OSCILLATION_TRIGGER_B];                   // R5
      end
      else if (done_any && !continuous_osc_on)
      begin
        if (sel_ref)
          reference_osc_run <= 1'b0;
        if (sel_a)
          sensor_a_osc_run <= 1'b0;                                // R6
        if (sel_b)
          sensor_b_osc_run <= 1'b0;                                // R5
      end
    end
  end

  // Software writes take precedence over counting in the same cycle
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      measurement_count <= `RFC_CNT_RST;                           // R11
    else if (ce)
    begin
      if (wr_mcl || wr_mch)
      begin
        if (wr_mcl)
          measurement_count[15:0] <= hwdata[15:0];                 // R11
        if (wr_mch)
          measurement_count[23:16] <= hwdata[7:0];                 // R11
      end
      else if (meas_step)
        measurement_count <= measurement_count + `RFC_CNT_ONE;     // R11
    end
  end

  // Time base runs up for the reference, down for a sensor
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      time_base_count <= `RFC_CNT_RST;                             // R7
    else if (ce)
    begin
      if (wr_tcl || wr_tch)
      begin
        if (wr_tcl)
          time_base_count[15:0] <= hwdata[15:0];                   // R7
        if (wr_tch)
          time_base_count[23:16] <= hwdata[7:0];                   // R8
      end
      else if (tb_step && sel_ref)
        time_base_count <= time_base_count + `RFC_CNT_ONE;
      else if (tb_step)
        time_base_count <= time_base_count - `RFC_CNT_ONE;
    end
  end

  // Flags: an event in the clearing cycle survives
  assign flag_set = {tb_wrap,                                       // R9
                     meas_wrap && event_count_mode_on,
                     done_any && sel_b,                             // R10
                     done_any && sel_a,                             // R10
                     done_any && sel_ref};                          // R10
  assign next_flag = (flag & ~(wr_iflg ? hwdata[`RFC_NFLAG-1:0]
                               : `RFC_FLAG_NONE)) | flag_set;

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      flag <= `RFC_FLAG_NONE;
      irq  <= 1'b0;
    end
    else if (ce)
    begin
      flag <= next_flag;                                            // R9
      irq  <= |(next_flag & mask);
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      ref_drive    <= 1'b0;
      sens_a_drive <= 1'b0;
      sens_b_drive <= 1'b0;
      osc_type_out <= `RFC_MODE_RST;
      channel_out  <= 1'b0;
    end
    else if (ce)
    begin
      ref_drive    <= converter_on && sel_ref;
      sens_a_drive <= converter_on && sel_a;
      sens_b_drive <= converter_on && sel_b;
      osc_type_out <= sensor_osc_type;                             // R4
      channel_out  <= channel_pick;
    end
  end

  sequence s_a_finish;
    ce && done_any && sel_a && !continuous_osc_on && !wr_trg;
  endsequence

  sequence s_trg_b_start;
    ce && wr_trg && hwdata[`OSCILLATION_TRIGGER_B];
  endsequence

  a_div_eight_tick: assert property (                              // R1
    ce && conv_tick && converter_clk_divider == 2'h3 && divide_on
    && !wr_clk |=> div_cnt == 3'h0)
    else $error("divide by 8 tick off phase");
  a_src_reserved_quiet: assert property (                          // R2
    converter_clk_source_sel == rfc_pkg::RFC_SRC_RESERVED |-> !conv_tick)
    else $error("reserved source ticks");
  a_evt_no_done: assert property (                                 // R3
    event_count_mode_on |-> !done_any && !tb_step)
    else $error("event mode ends oscillation");
  a_osc_type_follow: assert property (                             // R4
    ce ##1 ce |-> osc_type_out == $past(sensor_osc_type))
    else $error("type output lags");
  a_b_start_runs: assert property (                                // R5
    s_trg_b_start |=> sensor_b_osc_run)
    else $error("sensor B did not start");
  a_a_stop_write: assert property (                                // R6
    ce && wr_trg && !hwdata[`OSCILLATION_TRIGGER_A] |=> !sensor_a_osc_run)
    else $error("sensor A did not stop");
  a_tb_low_write: assert property (                                // R7
    ce && wr_tcl |=> time_base_count[15:0] == $past(hwdata[15:0]))
    else $error("time base low write lost");
  a_tch_read_zero: assert property (                               // R8
    ce && bus_state == rfc_pkg::RFC_BUS_READ_WAIT && ap_ok
    && ap_idx == `RFC_IDX_TCH |=> hreadyout ##0 hrdata[31:8] == 24'h0
    && hrdata[7:0] == $past(time_base_count[23:16]))
    else $error("time base high read wrong");
  a_tb_ovf_flag: assert property (                                 // R9
    ce && tb_wrap |=> flag[`RFC_FLG_TB_OVF])
    else $error("overflow flag missed");
  a_a_done_flag: assert property (                                 // R10
    s_a_finish |=> flag[`RFC_FLG_A] && !sensor_a_osc_run)
    else $error("sensor A completion wrong");
  a_meas_count_step: assert property (                             // R11
    ce && meas_step && !wr_mcl && !wr_mch
    |=> measurement_count == 24'($past(measurement_count) + 24'h1))
    else $error("measurement count step wrong");

endmodule : rfc_regs

// *** core/rfc_defines.svh ***
// Register indices, field positions and reset values of the converter
`ifndef RFC_DEFINES_SVH
`define RFC_DEFINES_SVH

`define RFC_IDX_CLK       16'h5067
`define RFC_IDX_CTL       16'h53a0
`define RFC_IDX_TRG       16'h53a2
`define RFC_IDX_MCL       16'h53a4
`define RFC_IDX_MCH       16'h53a6
`define RFC_IDX_TCL       16'h53a8
`define RFC_IDX_TCH       16'h53aa
`define RFC_IDX_IMSK      16'h53ac
`define RFC_IDX_IFLG      16'h53ae

`define CONVERTER_CLOCK_SETUP_DIV_HI    5
`define CONVERTER_CLOCK_SETUP_DIV_LO    4
`define CONVERTER_CLOCK_SETUP_SRC_HI    3
`define CONVERTER_CLOCK_SETUP_SRC_LO    2
`define CONVERTER_CLOCK_SETUP_GATE      0
`define CONVERTER_CONTROL_CONT      7
`define CONVERTER_CONTROL_EVT       6
`define CONVERTER_CONTROL_MODE_HI   5
`define CONVERTER_CONTROL_MODE_LO   4
`define CONVERTER_CONTROL_CHAN      1
`define CONVERTER_CONTROL_ON        0
`define OSCILLATION_TRIGGER_B         2
`define OSCILLATION_TRIGGER_A         1
`define OSCILLATION_TRIGGER_REF       0
`define RFC_FLG_TB_OVF    4
`define RFC_FLG_MS_OVF    3
`define RFC_FLG_B         2
`define RFC_FLG_A         1
`define RFC_FLG_REF       0
`define RFC_NFLAG         5

`define RFC_DIV_RST       2'h0
`define RFC_MODE_RST      2'h0
`define RFC_CNT_RST       24'h000000
`define RFC_CNT_MAX       24'hffffff
`define RFC_CNT_ONE       24'h000001
`define RFC_FLAG_NONE     5'h00
`define RFC_DIVCNT_RST    3'h0
`define RFC_DIVCNT_ONE    3'h1
`define RFC_IDX_TOP_ZERO  14'h0000

`endif

// *** core/rfc_pkg.sv ***
// Types shared by the converter register block
package rfc_pkg;

  typedef enum logic [1:0] {
    RFC_BUS_IDLE      = 2'b00,
    RFC_BUS_WRITE     = 2'b01,
    RFC_BUS_READ_WAIT = 2'b10,
    RFC_BUS_READ_DONE = 2'b11
  } rfc_bus_state_type;

  typedef enum logic [1:0] {
    RFC_SRC_INTERNAL  = 2'b00,
    RFC_SRC_LOW_SPEED = 2'b01,
    RFC_SRC_HIGH_SPD  = 2'b10,
    RFC_SRC_RESERVED  = 2'b11
  } converter_clock_setup_src_type;

  typedef enum logic [1:0] {
    RFC_OSC_DC_RES    = 2'b00,
    RFC_OSC_AC_RES    = 2'b01,
    RFC_OSC_CAP       = 2'b10,
    RFC_OSC_RESERVED  = 2'b11
  } rfc_osc_type_type;

endpackage : rfc_pkg

// *** bench/rfc_osc_model.sv ***
// Behavioural model of the external sensor and reference oscillator
`timescale 1ns/10ps

module rfc_osc_model (
  input  wire logic ref_clk,      // Converter clock
  input  wire logic sys_rst,      // Synchronous reset
  input  wire logic ref_drive,    // Reference drive
  input  wire logic sens_a_drive, // Sensor A drive
  input  wire logic sens_b_drive, // Sensor B drive
  input  wire logic slow,         // Stretch the period to four cycles
  output logic      osc_edge      // One pulse per oscillation edge
);
  logic [1:0] phase;

  // The element only oscillates while one of its drives is on
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      phase    <= 2'h0;
      osc_edge <= 1'b0;
    end
    else
    begin
      phase    <= phase + 2'h1;
      osc_edge <= (ref_drive | sens_a_drive | sens_b_drive) &
                  (!slow | (phase == 2'h3));
    end
  end
endmodule : rfc_osc_model

// *** bench/tb_rf_converter_control_regs.sv ***
// Self-checking bench of the converter register block
`timescale 1ns/10ps
`include "rfc_defines.svh"

module tb_rf_converter_control_regs;
  logic        ref_clk, sys_rst, hsel, hwrite, slow;
  logic        int_osc_tick, low_osc_tick, hi_osc_tick;
  logic [31:0] haddr, hwdata, rnd, q, tb, wv;
  logic [31:0] rt = 32'h6d50;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  wire logic   hreadyout, hresp, irq, osc_edge, channel_out;
  wire logic   ref_drive, sens_a_drive, sens_b_drive;
  wire logic [31:0] hrdata;
  wire logic [1:0]  osc_type_out;
  int          n_fail, n_tests, t0, k, e;
  int          n_tick = 0;
  logic [15:0] idx [8] = '{`RFC_IDX_CLK, `RFC_IDX_CTL, `RFC_IDX_MCL,
    `RFC_IDX_MCH, `RFC_IDX_TCL, `RFC_IDX_TCH, 16'h53b0, `RFC_IDX_TRG};

  rfc_regs dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .ce(1'b1),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .int_osc_tick(int_osc_tick), .low_osc_tick(low_osc_tick),
    .hi_osc_tick(hi_osc_tick),
    .osc_edge(osc_edge), .ref_drive(ref_drive),
    .sens_a_drive(sens_a_drive), .sens_b_drive(sens_b_drive),
    .osc_type_out(osc_type_out), .channel_out(channel_out), .irq(irq));

  rfc_osc_model osc_u (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .ref_drive(ref_drive), .sens_a_drive(sens_a_drive),
    .sens_b_drive(sens_b_drive), .slow(slow), .osc_edge(osc_edge));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
  endfunction : lfsr

  function automatic logic [31:0] addr(input logic [15:0] i);
    return {`RFC_IDX_TOP_ZERO, i, 2'b00};
  endfunction : addr

  function automatic logic [31:0] rw_mask(input logic [15:0] i);
    case (i)
      `RFC_IDX_CLK: return 32'h0000003d;
      `RFC_IDX_CTL: return 32'h000000f3;
      `RFC_IDX_MCL, `RFC_IDX_TCL: return 32'h0000ffff;
      `RFC_IDX_MCH, `RFC_IDX_TCH: return 32'h000000ff;
      default: return 32'h00000000;
    endcase
  endfunction : rw_mask

  task automatic stop_test;
    $display("checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test

  task automatic chk(input string what, input logic [31:0] x,
                     input logic [31:0] y);
    n_tests++;
    if (x !== y)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, x, y);
    end
  endtask : chk

  // Ready is judged half a cycle before the edge so it is settled
  task automatic wait_rdy(output logic [31:0] d);
    @(negedge ref_clk);
    while (hreadyout !== 1'b1)
      @(negedge ref_clk);
    d = hrdata;
    @(posedge ref_clk);
  endtask : wait_rdy

  task automatic xfer(input logic wr, input logic [15:0] i,
                      input logic [31:0] d, output logic [31:0] r);
    @(posedge ref_clk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= addr(i);
    hwrite <= wr;
    wait_rdy(r);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy(r);
  endtask : xfer

  task automatic wr(input logic [15:0] i, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, i, d, r);
  endtask : wr

  task automatic rd(input logic [15:0] i);
    xfer(1'b0, i, 32'h00000000, q);
  endtask : rd

  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // On-chip oscillator ticks; the count is what the design samples
  always @(posedge ref_clk)
  begin
    if (int_osc_tick === 1'b1)
      n_tick <= n_tick + 1;
    rt           <= lfsr(rt);
    int_osc_tick <= rt[0];
    low_osc_tick <= rt[1] & rt[2];
    hi_osc_tick  <= rt[3];
  end

  initial
  begin
    repeat (60000) @(posedge ref_clk);
    n_fail++;
    stop_test();
  end

  initial
  begin
    {hsel, hwrite, slow} = 3'h0;
    {haddr, hwdata} = 64'h0;
    htrans = 2'b00;
    hsize = 3'h2;
    n_fail = 0;
    n_tests = 0;
    rnd = 32'h6d50;
    sys_rst = 1'b1;
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    for (int j = 0; j < 8; j++)
    begin
      rd(idx[j]);
      chk("reset", (j == 0) ? 32'h4 : 32'h0, q);
    end
    for (int j = 0; j < 7; j++)
      for (int n = 0; n < 4; n++)
      begin
        rnd = lfsr(rnd);
        wv = (n == 0) ? 32'hffffffff : rnd;
        wr(idx[j], wv);
        rd(idx[j]);
        chk("read back", wv & rw_mask(idx[j]), q);
        if (j == 1)
          chk("pins", {wv[5:4], wv[1]}, {osc_type_out, channel_out});
      end
    for (int dv = 0; dv < 4; dv++)
    begin
      slow <= dv[0];
      wr(`RFC_IDX_TCL, 32'h0);
      wr(`RFC_IDX_TCH, 32'h80);
      wr(`RFC_IDX_MCH, 32'h0);
      wr(`RFC_IDX_CLK, (dv << 4) | 32'h1);
      wr(`RFC_IDX_CTL, 32'h1);
      wr(`RFC_IDX_TRG, 32'h4);
      t0 = n_tick;
      rd(`RFC_IDX_TRG);
      chk("sensor b run", 32'h4, q);
      chk("sensor b drive", 1'b1, sens_b_drive);
      repeat (400) @(posedge ref_clk);
      e = (n_tick - t0) >> dv;
      wr(`RFC_IDX_TRG, 32'h0);
      rd(`RFC_IDX_TRG);
      chk("sensor b stop", 32'h0, q);
      rd(`RFC_IDX_TCL);
      tb = q;
      rd(`RFC_IDX_TCH);
      k = 32'h800000 - ((q << 16) | tb);
      chk("divided count", 1'b1, (k >= e - 4) && (k <= e + 4));
    end
    wr(`RFC_IDX_MCL, 32'hfffe);
    wr(`RFC_IDX_MCH, 32'hff);
    wr(`RFC_IDX_IMSK, 32'h0);
    wr(`RFC_IDX_TRG, 32'h2);
    rd(`RFC_IDX_TRG);
    chk("sensor a run", 32'h2, q & 32'h2);
    for (k = 0; sens_a_drive !== 1'b0 && k < 300; k++)
      @(negedge ref_clk);
    rd(`RFC_IDX_TRG);
    chk("sensor a stop", 32'h0, q);
    rd(`RFC_IDX_IFLG);
    chk("sensor a done", 32'h2, q & 32'h2);
    chk("masked irq", 1'b0, irq);
    wr(`RFC_IDX_IMSK, 32'h2);
    repeat (2) @(posedge ref_clk);
    chk("irq on", 1'b1, irq);
    wr(`RFC_IDX_IFLG, 32'h2);
    repeat (2) @(posedge ref_clk);
    chk("irq cleared", 1'b0, irq);
    wr(`RFC_IDX_CTL, 32'h41);
    wr(`RFC_IDX_MCH, 32'h0);
    wr(`RFC_IDX_TCL, 32'h1234);
    wr(`RFC_IDX_TRG, 32'h1);
    repeat (100) @(posedge ref_clk);
    wr(`RFC_IDX_TRG, 32'h0);
    rd(`RFC_IDX_TCL);
    chk("event mode time base", 32'h1234, q);
    wr(`RFC_IDX_CTL, 32'h1);
    wr(`RFC_IDX_TCL, 32'hfff0);
    wr(`RFC_IDX_TCH, 32'hff);
    wr(`RFC_IDX_IMSK, 32'h10);
    wr(`RFC_IDX_TRG, 32'h1);
    for (k = 0; irq !== 1'b1 && k < 1000; k++)
      @(negedge ref_clk);
    rd(`RFC_IDX_IFLG);
    chk("overflow flag", 32'h10, q & 32'h10);
    wr(`RFC_IDX_TRG, 32'h0);
    wr(`RFC_IDX_IFLG, 32'h10);
    rd(`RFC_IDX_IFLG);
    chk("overflow cleared", 32'h0, q & 32'h10);
    chk("irq low", 1'b0, irq);
    stop_test();
  end
endmodule : tb_rf_converter_control_regs
